// ### phymc_ctrl.sv
// Functional notes
// [R01] Writing one to bit 15 starts a soft reset and hardware clears the bit when it ends.
// [R02] The soft reset restores only the standard control register, not the extended one.
// [R03] Bit 14 loops MAC transmit data back to MAC receive while set.
// [R04] With negotiation off the rate is the code {bit 6, bit 13}: 10, 100, 1000, 3 reserved.
// [R05] Bit 6 is read-only and reads one, so the forced code defaults to 1000 Mbps.
// [R06] Bit 12 turns auto-negotiation on or off and resets to one.
// [R07] Bit 11 is read-only, resets to zero and shows the power-down state.
// [R08] Bit 10 isolates the MAC interface pins while set and resets to zero.
// [R09] Writing one to bit 9 restarts negotiation and hardware clears the bit when done.
// [R10] Bit 8 selects full duplex when one and half duplex when zero, resetting to one.
// [R11] Bit 7 enables the collision signal test while set and resets to zero.
// [R12] The control register resets to 1140h and bits 5 to 0 read zero.
// [R13] Writes to read-only or reserved bits are ignored and reads have no side effect.
`include "phymc_defs.svh"
`default_nettype none
module phymc_ctrl
(
    input  wire logic        clock,                  // 20 MHz clock
    input  wire logic        rst_n,                  // async reset, active low
    input  wire logic [3:0]  avs_address,            // byte address
    input  wire logic        avs_read,               // read request
    input  wire logic        avs_write,              // write request
    input  wire logic [31:0] avs_writedata,          // write data
    input  wire logic [3:0]  avs_byteenable,         // byte lanes
    output logic      [31:0] avs_readdata,           // read data
    output logic             avs_waitrequest,        // stall
    input  wire logic        power_down_pin,         // power-down state, async
    output logic             loopback_on,            // mac tx to mac rx loop
    output logic             isolate_on,             // mac pins isolated
    output logic             collision_signal_check, // collision test on
    output logic             negotiation_on,         // auto-negotiation enabled
    output logic             negotiation_restart,    // restart pending or running
    output logic             full_duplex,            // duplex mode
    output logic [1:0]       link_speed,             // 0:10 1:100 2:1000
    output logic             link_speed_valid,       // link_speed is usable
    output logic             phy_reset_active,       // soft reset in progress
    output logic             negotiation_busy,       // negotiation running
    output logic [15:0]      ext_control             // extended control bits
);
    import phymc_pkg::*;

    phymc_top_s  s;
    phymc_top_s  next_s;
    phymc_seq_if seq_bus ();

    logic        req;
    logic        do_write;
    logic [15:0] mode_word;
    logic [15:0] merged;
    logic [15:0] status_word;
    logic [15:0] ext_merged;

    phymc_seq u_seq
    (
        .clock (clock),
        .rst_n (rst_n),
        .port  (seq_bus.seq)
    );

    // a literal cannot be bit-selected, so the reset word gets a name
    localparam logic [15:0] MODE_RESET = `PHYMC_MODE_CTRL_RESET;

    function automatic phymc_ctl_s ctl_default();
        phymc_ctl_s c;
        c.soft_reset             = MODE_RESET[`PHYMC_BIT_SOFT_RESET];
        c.loopback               = MODE_RESET[`PHYMC_BIT_LOOPBACK];
        c.speed_lsb              = MODE_RESET[`PHYMC_BIT_SPEED_LSB];
        c.negotiation_on         = MODE_RESET[`PHYMC_BIT_NEG_ON];
        c.isolate                = MODE_RESET[`PHYMC_BIT_ISOLATE];
        c.negotiation_restart    = MODE_RESET[`PHYMC_BIT_NEG_RESTART];
        c.full_duplex            = MODE_RESET[`PHYMC_BIT_DUPLEX];
        c.collision_signal_check = MODE_RESET[`PHYMC_BIT_COLL_CHECK];
        return c;
    endfunction

    localparam phymc_ctl_s CTL_RESET = ctl_default();

    // merges the written bytes over the current word
    function automatic logic [15:0] byte_merge(input logic [15:0] cur,
                                               input logic [15:0] wd,
                                               input logic [1:0]  be);
        logic [15:0] r;
        r       = cur;
        if (be[0])
        begin
            r[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // read view of the control register
    always_comb
    begin
        mode_word                          = 16'h0000;                     // R12
        mode_word[`PHYMC_BIT_SOFT_RESET]   = s.ctl.soft_reset;
        mode_word[`PHYMC_BIT_LOOPBACK]     = s.ctl.loopback;
        mode_word[`PHYMC_BIT_SPEED_LSB]    = s.ctl.speed_lsb;
        mode_word[`PHYMC_BIT_NEG_ON]       = s.ctl.negotiation_on;
        mode_word[`PHYMC_BIT_POWER_OFF]    = s.power_off_state;            // R07
        mode_word[`PHYMC_BIT_ISOLATE]      = s.ctl.isolate;
        mode_word[`PHYMC_BIT_NEG_RESTART]  = s.ctl.negotiation_restart;
        mode_word[`PHYMC_BIT_DUPLEX]       = s.ctl.full_duplex;
        mode_word[`PHYMC_BIT_COLL_CHECK]   = s.ctl.collision_signal_check;
        mode_word[`PHYMC_BIT_SPEED_MSB]    = `PHYMC_SPEED_MSB_VAL;         // R05
    end

    always_comb
    begin
        status_word                        = 16'h0000;
        status_word[`PHYMC_ST_POWER_OFF]   = s.power_off_state;
        status_word[`PHYMC_ST_NEG_DONE]    = s.neg_complete;
        status_word[`PHYMC_ST_RESET_BUSY]  = seq_bus.reset_busy;
        status_word[`PHYMC_ST_NEG_BUSY]    = seq_bus.neg_busy;
    end

    assign req        = avs_read | avs_write;
    // writes land on the edge where waitrequest is seen low
    assign do_write   = avs_write & s.ack;
    assign merged     = byte_merge(mode_word, avs_writedata[15:0], avs_byteenable[1:0]);
    assign ext_merged = byte_merge(s.ext, avs_writedata[15:0], avs_byteenable[1:0]);

    always_comb
    begin
        next_s             = s;
        next_s.start_reset = 1'b0;
        next_s.start_neg   = 1'b0;
        next_s.kick        = 1'b0;

        // two-stage synchroniser for the power-down pin
        next_s.pd_meta         = power_down_pin;
        next_s.power_off_state = s.pd_meta;                                // R07

        // one wait cycle, then the answer
        next_s.ack = req & ~s.ack;

        // hardware clears first so a same-cycle write set wins
        if (seq_bus.reset_done)
        begin
            next_s.ctl.soft_reset = 1'b0;                                  // R01
            // a fresh negotiation follows the soft reset when negotiation is on
            if (s.ctl.negotiation_on)
            begin
                next_s.start_neg = 1'b1;
            end
        end
        if (seq_bus.neg_done)
        begin
            next_s.ctl.negotiation_restart = 1'b0;                         // R09
            next_s.neg_complete            = 1'b1;
        end
        if (s.kick && s.ctl.negotiation_on)
        begin
            next_s.start_neg = 1'b1;
        end

        if (req && !s.ack && avs_read)
        begin
            case (avs_address)
                `PHYMC_ADDR_MODE_CTRL: next_s.rdata = {16'h0000, mode_word};   // R13
                `PHYMC_ADDR_EXT_CTRL:  next_s.rdata = {16'h0000, s.ext};
                `PHYMC_ADDR_STATUS:    next_s.rdata = {16'h0000, status_word};
                default:               next_s.rdata = 32'h0000_0000;
            endcase
        end

        if (do_write)
        begin
            case (avs_address)
                `PHYMC_ADDR_MODE_CTRL:
                begin
                    if (merged[`PHYMC_BIT_SOFT_RESET])
                    begin
                        // only the standard register returns to defaults
                        next_s.ctl             = ctl_default();            // R02
                        next_s.ctl.soft_reset  = 1'b1;                     // R01
                        next_s.start_reset     = 1'b1;                     // R01
                        next_s.start_neg       = 1'b0;
                        next_s.neg_complete    = 1'b0;
                    end
                    else
                    begin
                        // read-only and reserved bits are simply not stored
                        next_s.ctl.loopback    = merged[`PHYMC_BIT_LOOPBACK];      // R03
                        next_s.ctl.speed_lsb   = merged[`PHYMC_BIT_SPEED_LSB];     // R04
                        next_s.ctl.negotiation_on = merged[`PHYMC_BIT_NEG_ON];     // R06
                        next_s.ctl.isolate     = merged[`PHYMC_BIT_ISOLATE];       // R08
                        next_s.ctl.full_duplex = merged[`PHYMC_BIT_DUPLEX];        // R10
                        next_s.ctl.collision_signal_check =
                            merged[`PHYMC_BIT_COLL_CHECK];                         // R11
                        // turning negotiation on starts one
                        if (merged[`PHYMC_BIT_NEG_ON] && !s.ctl.negotiation_on)
                        begin
                            next_s.kick         = 1'b1;
                            next_s.neg_complete = 1'b0;
                        end
                        if (!merged[`PHYMC_BIT_NEG_ON])
                        begin
                            next_s.neg_complete            = 1'b0;
                            next_s.ctl.negotiation_restart = 1'b0;
                        end
                        // zero written to bit 9 is ignored: hardware owns it
                        else if (avs_byteenable[1] &&
                                 avs_writedata[`PHYMC_BIT_NEG_RESTART])
                        begin
                            next_s.ctl.negotiation_restart = 1'b1;         // R09
                            next_s.start_neg               = 1'b1;         // R09
                            next_s.neg_complete            = 1'b0;
                        end
                    end
                end
                `PHYMC_ADDR_EXT_CTRL:
                begin
                    next_s.ext = ext_merged;
                end
                default:
                begin
                    next_s.ext = s.ext;                                    // R13
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // negotiation is on after reset, so run one right away
            s <= '{ctl:     CTL_RESET,                                     // R12
                   ext:     `PHYMC_EXT_CTRL_RESET,
                   kick:    1'b1,                                          // R06
                   default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign seq_bus.start_reset = s.start_reset;
    assign seq_bus.start_neg   = s.start_neg;

    assign avs_waitrequest        = req & ~s.ack;
    assign avs_readdata           = s.rdata;
    assign loopback_on            = s.ctl.loopback;                        // R03
    assign isolate_on             = s.ctl.isolate;                         // R08
    assign collision_signal_check = s.ctl.collision_signal_check;          // R11
    assign negotiation_on         = s.ctl.negotiation_on;                  // R06
    assign negotiation_restart    = s.ctl.negotiation_restart;
    assign full_duplex            = s.ctl.full_duplex;                     // R10
    assign phy_reset_active       = s.ctl.soft_reset;
    assign negotiation_busy       = seq_bus.neg_busy;

    // negotiated rate is taken as the top rate; forced code otherwise
    always_comb
    begin
        if (s.ctl.negotiation_on)
        begin
            link_speed       = `PHYMC_SPEED_1000;
            link_speed_valid = s.neg_complete;
        end
        else
        begin
            link_speed       = {`PHYMC_SPEED_MSB_VAL, s.ctl.speed_lsb};    // R04
            link_speed_valid = (link_speed != `PHYMC_SPEED_RSVD) && !s.ctl.soft_reset;
        end
    end

    assign ext_control = s.ext;                                            // R02

endmodule
`default_nettype wire

// ### phymc_defs.svh
`ifndef PHYMC_DEFS_SVH
`define PHYMC_DEFS_SVH

// register byte addresses on the avalon slave
`define PHYMC_ADDR_W            4
`define PHYMC_ADDR_MODE_CTRL    4'h0
`define PHYMC_ADDR_EXT_CTRL     4'h4
`define PHYMC_ADDR_STATUS       4'h8

// basic_mode_control field positions
`define PHYMC_BIT_SOFT_RESET    15
`define PHYMC_BIT_LOOPBACK      14
`define PHYMC_BIT_SPEED_LSB     13
`define PHYMC_BIT_NEG_ON        12
`define PHYMC_BIT_POWER_OFF     11
`define PHYMC_BIT_ISOLATE       10
`define PHYMC_BIT_NEG_RESTART   9
`define PHYMC_BIT_DUPLEX        8
`define PHYMC_BIT_COLL_CHECK    7
`define PHYMC_BIT_SPEED_MSB     6

`define PHYMC_MODE_CTRL_RESET   16'h1140
`define PHYMC_SPEED_MSB_VAL     1'h1
`define PHYMC_EXT_CTRL_RESET    16'h0000
`define PHYMC_SPEED_1000        2'h2
`define PHYMC_SPEED_RSVD        2'h3

// status register bit positions
`define PHYMC_ST_POWER_OFF      0
`define PHYMC_ST_NEG_DONE       1
`define PHYMC_ST_RESET_BUSY     2
`define PHYMC_ST_NEG_BUSY       3

// timing, clock 20 MHz
`define PHYMC_CLK_MHZ           64'd20
`define PHYMC_CNT_W             12
`define PHYMC_SOFT_RESET_NS     64'd1000
`define PHYMC_NEG_NS            64'd100000
`define PHYMC_RESET_CYC  12'((`PHYMC_SOFT_RESET_NS * `PHYMC_CLK_MHZ + 64'd999) / 64'd1000)
`define PHYMC_NEG_CYC    12'((`PHYMC_NEG_NS * `PHYMC_CLK_MHZ) / 64'd1000)

`endif

// ### phymc_pkg.sv
`default_nettype none
package phymc_pkg;

    typedef enum logic [1:0]
    {
        SEQ_IDLE  = 2'h0,
        SEQ_RESET = 2'h1,
        SEQ_NEG   = 2'h2
    } phymc_seq_e;

    typedef struct packed
    {
        phymc_seq_e  st;
        logic [11:0] cnt;
        logic        reset_done;
        logic        neg_done;
    } phymc_seq_s;

    typedef struct packed
    {
        logic soft_reset;
        logic loopback;
        logic speed_lsb;
        logic negotiation_on;
        logic isolate;
        logic negotiation_restart;
        logic full_duplex;
        logic collision_signal_check;
    } phymc_ctl_s;

    typedef struct packed
    {
        phymc_ctl_s  ctl;
        logic [15:0] ext;
        logic        neg_complete;
        logic        kick;
        logic        pd_meta;
        logic        power_off_state;
        logic        ack;
        logic [31:0] rdata;
        logic        start_reset;
        logic        start_neg;
    } phymc_top_s;

endpackage
`default_nettype wire

// ### phymc_seq_if.sv
`default_nettype none
interface phymc_seq_if;
    logic start_reset;
    logic start_neg;
    logic reset_busy;
    logic neg_busy;
    logic reset_done;
    logic neg_done;

    modport ctrl (output start_reset, output start_neg,
                  input reset_busy, input neg_busy, input reset_done, input neg_done);
    modport seq  (input start_reset, input start_neg,
                  output reset_busy, output neg_busy, output reset_done, output neg_done);
endinterface
`default_nettype wire

// ### phymc_seq.sv
`include "phymc_defs.svh"
`default_nettype none
module phymc_seq
(
    input  wire logic clock,  // 20 MHz clock
    input  wire logic rst_n,  // async reset, active low
    phymc_seq_if.seq  port    // start requests and progress
);
    import phymc_pkg::*;

    phymc_seq_s s;
    phymc_seq_s next_s;

    always_comb
    begin
        next_s            = s;
        next_s.reset_done = 1'b0;
        next_s.neg_done   = 1'b0;
        case (s.st)
            SEQ_IDLE:
            begin
                if (port.start_reset)
                begin
                    next_s.st  = SEQ_RESET;
                    next_s.cnt = `PHYMC_RESET_CYC - 12'h001;
                end
                else if (port.start_neg)
                begin
                    next_s.st  = SEQ_NEG;
                    next_s.cnt = `PHYMC_NEG_CYC - 12'h001;
                end
            end
            SEQ_RESET:
            begin
                if (s.cnt == 12'h000)
                begin
                    next_s.st         = SEQ_IDLE;
                    next_s.reset_done = 1'b1;
                end
                else
                begin
                    next_s.cnt = s.cnt - 12'h001;
                end
            end
            SEQ_NEG:
            begin
                // a soft reset aborts a running negotiation
                if (port.start_reset)
                begin
                    next_s.st  = SEQ_RESET;
                    next_s.cnt = `PHYMC_RESET_CYC - 12'h001;
                end
                else if (port.start_neg)
                begin
                    next_s.cnt = `PHYMC_NEG_CYC - 12'h001;
                end
                else if (s.cnt == 12'h000)
                begin
                    next_s.st       = SEQ_IDLE;
                    next_s.neg_done = 1'b1;
                end
                else
                begin
                    next_s.cnt = s.cnt - 12'h001;
                end
            end
            default:
            begin
                next_s.st = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '{st: SEQ_IDLE, cnt: 12'h000, reset_done: 1'b0, neg_done: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign port.reset_busy = (s.st == SEQ_RESET);
    assign port.neg_busy   = (s.st == SEQ_NEG);
    assign port.reset_done = s.reset_done;
    assign port.neg_done   = s.neg_done;

endmodule
`default_nettype wire

// ### phymc_ctrl_properties.sv
`default_nettype none
module phymc_ctrl_properties
(
    input wire logic        clock,                  // 20 MHz clock
    input wire logic        rst_n,                  // async reset
    input wire logic [3:0]  avs_address,            // byte address
    input wire logic        avs_read,               // read request
    input wire logic        avs_write,              // write request
    input wire logic [31:0] avs_writedata,          // write data
    input wire logic [3:0]  avs_byteenable,         // byte lanes
    input wire logic [31:0] avs_readdata,           // read data
    input wire logic        avs_waitrequest,        // stall
    input wire logic        loopback_on,            // loopback
    input wire logic        isolate_on,             // isolate
    input wire logic        collision_signal_check, // collision test
    input wire logic        negotiation_on,         // negotiation enable
    input wire logic        negotiation_restart,    // restart bit
    input wire logic        full_duplex,            // duplex
    input wire logic [1:0]  link_speed,             // rate code
    input wire logic        link_speed_valid,       // rate usable
    input wire logic        phy_reset_active,       // soft reset
    input wire logic        negotiation_busy        // negotiation running
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] wd_q;
    logic        done_wr;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // write data of the access that completed last cycle
    always_ff @(posedge clock)
    begin
        wd_q <= avs_writedata;
    end
    assign done_wr = avs_write && !avs_waitrequest && avs_address == 4'h0;

    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    reset_ends_a: assert property (phy_reset_active |-> ##[1:25] !phy_reset_active)
        else $error("soft reset did not clear itself");
    soft_default_a: assert property ($rose(phy_reset_active) |-> negotiation_on && full_duplex
        && !loopback_on && !isolate_on && !collision_signal_check)
        else $error("soft reset did not restore control defaults");
    mode_reset_a: assert property ($rose(rst_n) |-> negotiation_on && full_duplex && !isolate_on
        && !loopback_on && !collision_signal_check)
        else $error("control outputs wrong after reset");
    field_write_a: assert property (done_wr && avs_byteenable[1:0] == 2'h3 && !avs_writedata[15]
        |=> {loopback_on, isolate_on, full_duplex, collision_signal_check}
        == {wd_q[14], wd_q[10], wd_q[8], wd_q[7]})
        else $error("control fields do not follow write");
    neg_speed_a: assert property (negotiation_on |-> link_speed == 2'h2)
        else $error("negotiated rate code wrong");
    forced_speed_a: assert property (link_speed_valid && !negotiation_on
        |-> link_speed == 2'h2 && !phy_reset_active)
        else $error("forced rate valid with bad code");
    restart_busy_a: assert property ($rose(negotiation_restart) |=> negotiation_busy)
        else $error("restart did not start negotiation");
    restart_clear_a: assert property ($fell(negotiation_busy)
        |-> ##[0:1] !negotiation_restart)
        else $error("restart bit not cleared at end");
    read_fixed_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
        |-> avs_readdata[6:0] == 7'h40 && avs_readdata[31:16] == 16'h0)
        else $error("fixed control bits read wrong");
endmodule

bind phymc_ctrl phymc_ctrl_properties chk_i
(
    .clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .loopback_on, .isolate_on,
    .collision_signal_check, .negotiation_on, .negotiation_restart, .full_duplex,
    .link_speed, .link_speed_valid, .phy_reset_active, .negotiation_busy
);
`default_nettype wire

// ### phymc_host.sv
`default_nettype none
module phymc_host
(
    input  wire logic        clock,           // 20 MHz clock
    input  wire logic        avs_waitrequest, // stall
    input  wire logic [31:0] avs_readdata,    // read data
    output var  logic [3:0]  avs_address,     // byte address
    output var  logic        avs_read,        // read request
    output var  logic        avs_write,       // write request
    output var  logic [31:0] avs_writedata,   // write data
    output var  logic [3:0]  avs_byteenable   // byte lanes
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
    end

    // one access; the host sets bit 9 only by writing one to it
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clock);
        avs_address    <= a;
        avs_read       <= !w;
        avs_write      <= w;
        avs_writedata  <= {16'h0, d};
        avs_byteenable <= be;
        @(posedge clock);
        // no fixed latency assumed; the bench timeout ends a hang
        while (avs_waitrequest !== 1'b0)
            @(posedge clock);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### phy_basic_mode_control_test.sv
`default_nettype none
module phy_basic_mode_control_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock;
    logic        rst_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        power_down_pin;
    logic        loopback_on;
    logic        isolate_on;
    logic        collision_signal_check;
    logic        negotiation_on;
    logic        negotiation_restart;
    logic        full_duplex;
    logic [1:0]  link_speed;
    logic        link_speed_valid;
    logic        phy_reset_active;
    logic        negotiation_busy;
    logic [15:0] ext_control;
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;

    phymc_ctrl dut (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .power_down_pin, .loopback_on,
        .isolate_on, .collision_signal_check, .negotiation_on, .negotiation_restart,
        .full_duplex, .link_speed, .link_speed_valid, .phy_reset_active,
        .negotiation_busy, .ext_control);
    phymc_host host (.clock, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable);

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
        logic [31:0] q;
        host.acc(1'b1, a, d, be, q);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        logic [31:0] q;
        host.acc(1'b0, a, 16'h0, 4'hf, q);
        chk(q, {16'h0, exp});
    endtask

    // bounded wait; three quiet edges bridge the gap from soft reset to negotiation
    task automatic settle;
        int quiet;
        quiet = 0;
        for (int n = 0; n < 2600 && quiet < 3; n++)
        begin
            @(posedge clock);
            quiet = (phy_reset_active === 1'b0 && negotiation_busy === 1'b0) ? quiet + 1 : 0;
        end
    endtask

    task automatic t_reset;
        rdc(4'h0, 16'h1140);
        chk({negotiation_on, full_duplex, loopback_on, isolate_on, collision_signal_check},
            5'h18);
        $display("reset values done");
    endtask

    task automatic t_fields;
        wr(4'h0, 16'h0000, 4'h3);
        rdc(4'h0, 16'h0040);
        chk({link_speed_valid, link_speed}, 3'h6);
        wr(4'h0, 16'h2000, 4'h3);
        rdc(4'h0, 16'h2040);
        chk({link_speed_valid, link_speed}, 3'h3);
        wr(4'h0, 16'h4580, 4'h3);
        rdc(4'h0, 16'h45c0);
        chk({loopback_on, isolate_on, full_duplex, collision_signal_check}, 4'hf);
        wr(4'h0, 16'h087f, 4'h3);
        rdc(4'h0, 16'h0040);
        // only the low lane is enabled, so just bit 7 may change
        wr(4'h0, 16'hffff, 4'h1);
        rdc(4'h0, 16'h00c0);
        $display("field access done");
    endtask

    task automatic t_restart;
        wr(4'h0, 16'h0200, 4'h3);
        rdc(4'h0, 16'h0040);
        wr(4'h0, 16'h1000, 4'h3);
        wr(4'h0, 16'h1200, 4'h3);
        rdc(4'h0, 16'h1240);
        chk(negotiation_busy, 1'b1);
        settle();
        rdc(4'h0, 16'h1040);
        chk({link_speed_valid, link_speed}, 3'h6);
        $display("restart done");
    endtask

    task automatic t_soft;
        wr(4'h4, 16'ha5c3, 4'h3);
        wr(4'h0, 16'h0580, 4'h3);
        wr(4'h0, 16'h8000, 4'h2);
        repeat (2) @(posedge clock);
        chk(phy_reset_active, 1'b1);
        chk({negotiation_on, full_duplex, loopback_on, isolate_on, collision_signal_check},
            5'h18);
        settle();
        rdc(4'h0, 16'h1140);
        rdc(4'h4, 16'ha5c3);
        chk(ext_control, 16'ha5c3);
        $display("soft reset done");
    endtask

    task automatic t_power;
        power_down_pin <= 1'b1;
        repeat (4) @(posedge clock);
        rdc(4'h0, 16'h1940);
        rdc(4'h8, 16'h0003);
        wr(4'h0, 16'h1100, 4'h3);
        rdc(4'h0, 16'h1940);
        power_down_pin <= 1'b0;
        repeat (4) @(posedge clock);
        rdc(4'h0, 16'h1140);
        rdc(4'hc, 16'h0000);
        rdc(4'hc, 16'h0000);
        $display("power and unmapped done");
    endtask

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // whole run needs about 4100 cycles
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            print_verdict();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        power_down_pin = 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_fields();
        t_restart();
        t_soft();
        t_power();
        print_verdict();
    end
endmodule
`default_nettype wire
